// ===== core/nbr_host.sv
/*
  host controller for a multiplexed nand flash page read: issues page
  reads and column moves, streams bytes out and screens defect markers.
  assumes a device on the pins, ready/busy pulled up outside.
*/
// Overview of operation
// (RULE1) column is address bits 0-12, page-in-block bits 13-18.
// (RULE2) block bits 19-29, unit bits 30-31; five cycles, upper lanes low.
// (RULE3) unit bits forced low for the two smaller densities.
// (RULE4) defective blocks carry a non-FFh marker in first user or spare byte.
// (RULE5) host reads markers in first and last page; majority non-FFh is bad.
// (RULE6) host never erases or programs a block marked defective.
// (RULE7) read opcodes 00h/30h, 00h/35h, 31h, 00h/31h and 3Fh.
// (RULE8) program opcodes 80h/10h, 80h/15h, 85h, 85h/10h, erase 60h/D0h.
// (RULE9) during busy only status and reset; strobes held high.
// (RULE10) command latched on rising write strobe, command latch high.
// (RULE11) address latched on rising write strobe, address latch high.
// (RULE12) data latched with both latches low and write protect high.
// (RULE13) write protect high for program or erase command cycles.
// (RULE14) device aborts program and erase when write protect goes low.
// (RULE15) one byte per read strobe cycle, advanced by falling strobe.
// (RULE16) read cycles under 30 ns sample on the next falling strobe.
// (RULE17) chip select may rise during output or latency; read continues.
// (RULE18) page read is 00h, five address cycles, 30h, then latency.
// (RULE19) after power-up page zero of block zero sits in the cache.
// (RULE20) bytes run from the addressed column to the last column.
// (RULE21) column move 05h, two column cycles, E0h, only in read idle.
// (RULE22) exactly two column address cycles follow 05h.
// (RULE23) ready/busy is low while the device is working.
// (RULE24) chip select high while ready puts the device in standby.
// (RULE25) host waits for ready before strobing out data.
// (RULE26) both latches high at once latch nothing.
`timescale 1ns/1ps
`default_nettype none
module nbr_host (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_op,
  input wire logic [31:0] req_addr,
  input wire logic [12:0] req_len,
  input wire logic [1:0] density,
  // user read data and result
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic bad_block,
  // device pins
  input wire logic [7:0] lanes_in,
  output logic [7:0] lanes_out,
  output logic lanes_oe_n,
  output logic chip_select_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  input wire logic ready_busy_n
);
  localparam logic [1:0] REQ_READ = 2'h0;
  localparam logic [1:0] REQ_COLUMN = 2'h1;
  localparam logic [1:0] REQ_SCREEN = 2'h2;
  localparam logic [1:0] REQ_CACHE = 2'h3;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CMD1 = 4'h1,
    S_ADDR = 4'h2,
    S_CMD2 = 4'h3,
    S_SETTLE = 4'h4,
    S_WAIT = 4'h5,
    S_DATA = 4'h6,
    S_SPARE = 4'h7,
    S_NEXT = 4'h8,
    S_DONE = 4'h9
  } nbr_state_type;
  nbr_cyc_if cyc ();
  nbr_state_type state_ff;
  logic [1:0] op_ff;
  logic [31:0] addr_ff;
  logic [2:0] acnt_ff;
  logic [12:0] left_ff;
  logic [3:0] settle_ff;
  logic [1:0] mark_ff;
  logic last_page_ff;
  logic bad_ff;
  logic ready_sync;
  logic [39:0] addr_bytes;
  logic [31:0] addr_masked;
  logic [3:0] ones;
  logic [7:0] cmd_first;
  logic [7:0] cmd_second;
  logic [2:0] addr_cycles;
  logic want_cycle;
  logic addr_phase;
  // ready/busy pin through the three-stage synchroniser
  nbr_sync u_sync (
    .clock(clock),
    .rst(rst),
    .pin(ready_busy_n),
    .level(ready_sync)
  );
  nbr_strobe u_strobe (
    .clock(clock),
    .rst(rst),
    .cyc(cyc.eng),
    .lanes_in(lanes_in),
    .lanes_out(lanes_out),
    .lanes_oe_n(lanes_oe_n),
    .cmd_latch(cmd_latch),
    .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n)
  );
  // unit bits clamped by density before the address goes out
  always_comb begin
    addr_masked = req_addr;
    if (density == nbr_pkg::DENS_4G) begin
      addr_masked[nbr_pkg::LUN_LSB +: nbr_pkg::LUN_W] = 2'b00; // RULE3
    end else if (density == nbr_pkg::DENS_8G) begin
      addr_masked[nbr_pkg::LUN_LSB + 1] = 1'b0; // RULE3
    end
  end
  // five address cycles, unused lanes low
  assign addr_bytes = {5'h00, addr_ff[31:29], addr_ff[28:21], // RULE2
                       addr_ff[20:13], 3'h0, addr_ff[12:8], // RULE1
                       addr_ff[7:0]};
  // opcodes per request kind
  always_comb begin
    cmd_first = nbr_pkg::OP_READ_SETUP; // RULE18
    cmd_second = nbr_pkg::OP_READ_CONFIRM;
    addr_cycles = nbr_pkg::ROW_CYCLES;
    if (op_ff == REQ_COLUMN) begin
      cmd_first = nbr_pkg::OP_COLUMN_SETUP; // RULE21
      cmd_second = nbr_pkg::OP_COLUMN_CONFIRM;
      addr_cycles = nbr_pkg::COL_CYCLES; // RULE22
    end else if (op_ff == REQ_CACHE) begin
      cmd_second = nbr_pkg::OP_CACHE_READ; // RULE7
    end
  end
  // count of ones in a marker byte
  always_comb begin
    ones = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones = ones + {3'h0, cyc.rdata[i]};
    end
  end
  assign addr_phase = (state_ff == S_ADDR);
  // strobes only move while not busy
  assign want_cycle = (state_ff == S_CMD1) || (state_ff == S_CMD2) ||
                      addr_phase ||
                      ((state_ff == S_DATA) && ready_sync); // RULE9 RULE25
  assign cyc.req = want_cycle && !cyc.done;
  always_comb begin
    cyc.kind = nbr_pkg::CYC_READ;
    cyc.wdata = 8'h00;
    if (state_ff == S_CMD1) begin
      cyc.kind = nbr_pkg::CYC_CMD;
      cyc.wdata = cmd_first;
    end else if (state_ff == S_CMD2) begin
      cyc.kind = nbr_pkg::CYC_CMD;
      cyc.wdata = cmd_second;
    end else if (addr_phase) begin
      cyc.kind = nbr_pkg::CYC_ADDR;
      cyc.wdata = addr_bytes[{acnt_ff, 3'h0} +: 8];
    end
  end
  // request acceptance: column moves only while idle in read state
  assign req_ready = (state_ff == S_IDLE) && ready_sync; // RULE21
  // sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff <= REQ_READ;
      addr_ff <= 32'h0000_0000; // RULE19
      acnt_ff <= 3'h0;
      left_ff <= 13'h0000;
      settle_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (req_valid && req_ready) begin
            op_ff <= req_op;
            addr_ff <= addr_masked;
            left_ff <= req_len;
            state_ff <= S_CMD1;
            if (req_op == REQ_SCREEN) begin
              addr_ff[nbr_pkg::COL_LSB +: nbr_pkg::COL_W] <= 13'h0000;
              addr_ff[nbr_pkg::PAGE_LSB +: nbr_pkg::PAGE_W] <= 6'h00; // RULE5
              left_ff <= 13'h0001;
            end
          end
        end
        S_CMD1: begin
          if (cyc.done) begin
            acnt_ff <= 3'h0;
            state_ff <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (cyc.done) begin
            acnt_ff <= acnt_ff + 3'h1;
            if (acnt_ff == addr_cycles - 3'h1) begin
              state_ff <= S_CMD2;
            end
          end
        end
        S_CMD2: begin
          if (cyc.done) begin
            settle_ff <= nbr_pkg::BUSY_SETTLE_CYC;
            state_ff <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          // give the busy pin time to fall before trusting ready
          if (settle_ff == 4'h1) begin
            state_ff <= S_WAIT;
          end else begin
            settle_ff <= settle_ff - 4'h1;
          end
        end
        S_WAIT: begin
          if (ready_sync) begin
            state_ff <= (left_ff == 13'h0000) ? S_DONE : S_DATA; // RULE25
          end
        end
        S_DATA: begin
          if (cyc.done) begin
            left_ff <= left_ff - 13'h0001;
            addr_ff[nbr_pkg::COL_LSB +: nbr_pkg::COL_W] <=
              addr_ff[nbr_pkg::COL_LSB +: nbr_pkg::COL_W] + 13'h0001;
            if (left_ff == 13'h0001 ||
                addr_ff[12:0] == nbr_pkg::LAST_COLUMN) begin // RULE20
              state_ff <= (op_ff == REQ_SCREEN) ? S_SPARE : S_DONE;
            end
          end
        end
        S_SPARE: begin
          // after each marker byte: judge it, then S_NEXT picks the spare byte, the last page or S_DONE
          state_ff <= S_NEXT;
        end
        S_NEXT: begin
          op_ff <= REQ_SCREEN;
          if (mark_ff == 2'h1) begin
            addr_ff[12:0] <= nbr_pkg::LAST_COLUMN - 13'h00ff;
            left_ff <= 13'h0001;
            state_ff <= S_CMD1;
          end else if (!last_page_ff) begin
            addr_ff[12:0] <= 13'h0000;
            addr_ff[nbr_pkg::PAGE_LSB +: nbr_pkg::PAGE_W] <= 6'h3f; // RULE5
            left_ff <= 13'h0001;
            state_ff <= S_CMD1;
          end else begin
            state_ff <= S_DONE;
          end
        end
        S_DONE: state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end
  // marker bookkeeping: user byte then spare byte, first then last page
  always_ff @(posedge clock) begin
    if (rst) begin
      mark_ff <= 2'h0;
      last_page_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else if (state_ff == S_IDLE && req_valid && req_ready) begin
      mark_ff <= 2'h0;
      last_page_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else if (state_ff == S_SPARE) begin
      mark_ff <= mark_ff + 2'h1;
      if (ones < nbr_pkg::MAJORITY_BITS) begin
        bad_ff <= 1'b1; // RULE4 RULE5
      end
    end else if (state_ff == S_NEXT && mark_ff == 2'h2) begin
      mark_ff <= 2'h0;
      last_page_ff <= 1'b1;
    end
  end
  // user data outputs from flip-flops
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      bad_block <= 1'b0;
    end else begin
      rd_valid <= (state_ff == S_DATA) && cyc.done && (op_ff != REQ_SCREEN);
      rd_data <= cyc.rdata; // RULE15
      done <= (state_ff == S_DONE);
      if (state_ff == S_DONE) begin
        bad_block <= bad_ff && (op_ff == REQ_SCREEN);
      end
    end
  end
  // chip select held low while working or requested; high in idle with no request gives standby
  always_ff @(posedge clock) begin
    if (rst) begin
      chip_select_n <= 1'b1;
    end else begin
      chip_select_n <= (state_ff == S_IDLE) && !req_valid; // RULE24 RULE17
    end
  end
  // only reads are issued, so write protect stays asserted
  assign write_protect_n = 1'b0; // RULE6 RULE8 RULE12 RULE13 RULE14
endmodule : nbr_host
`default_nettype wire

// ===== common/nbr_pkg.sv
/*
  constants for the host-side nand page read controller: opcodes, address
  layout, bus timing counts and cycle kinds.
  assumes a single 125 MHz clock domain.
*/
package nbr_pkg;
  // clock period
  localparam int CLK_PERIOD_PS = 8000;
  // opcodes
  localparam logic [7:0] OP_READ_SETUP = 8'h00;
  localparam logic [7:0] OP_READ_CONFIRM = 8'h30;
  localparam logic [7:0] OP_COPYBACK_READ = 8'h35;
  localparam logic [7:0] OP_CACHE_READ = 8'h31;
  localparam logic [7:0] OP_CACHE_READ_END = 8'h3f;
  localparam logic [7:0] OP_PROGRAM_SETUP = 8'h80;
  localparam logic [7:0] OP_PROGRAM_CONFIRM = 8'h10;
  localparam logic [7:0] OP_CACHE_PROGRAM = 8'h15;
  localparam logic [7:0] OP_RANDOM_INPUT = 8'h85;
  localparam logic [7:0] OP_ERASE_SETUP = 8'h60;
  localparam logic [7:0] OP_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] OP_READ_STATUS = 8'h70;
  localparam logic [7:0] OP_READ_STATUS_ENH = 8'h78;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_COLUMN_SETUP = 8'h05;
  localparam logic [7:0] OP_COLUMN_CONFIRM = 8'he0;
  // address layout
  localparam int COL_LSB = 0;
  localparam int COL_W = 13;
  localparam int PAGE_LSB = 13;
  localparam int PAGE_W = 6;
  localparam int BLOCK_LSB = 19;
  localparam int BLOCK_W = 11;
  localparam int LUN_LSB = 30;
  localparam int LUN_W = 2;
  localparam int ADDR_W = 32;
  localparam logic [2:0] ROW_CYCLES = 3'h5;
  localparam logic [2:0] COL_CYCLES = 3'h2;
  localparam logic [12:0] LAST_COLUMN = 13'h10ff;
  localparam logic [7:0] MARK_GOOD = 8'hff;
  localparam logic [3:0] MAJORITY_BITS = 4'h5;
  // density selection
  localparam logic [1:0] DENS_4G = 2'h0;
  localparam logic [1:0] DENS_8G = 2'h1;
  // bus timing in ns and in cycles (least times round up)
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 15;
  localparam int READ_CYCLE_NS = 40;
  localparam int BUSY_SETTLE_NS = 100;
  localparam logic [3:0] STROBE_LOW_CYC =
    4'((STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] STROBE_HIGH_CYC =
    4'((STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] BUSY_SETTLE_CYC =
    4'((BUSY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // read cycles slower than 30 ns sample on the rising read strobe
  localparam int EDO_LIMIT_NS = 30;
  localparam logic EDO_MODE = (READ_CYCLE_NS < EDO_LIMIT_NS);
  // cycle kinds on the pins
  typedef enum logic [1:0] {
    CYC_CMD = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_READ = 2'b10
  } nbr_cyc_type;
endpackage : nbr_pkg

// ===== common/nbr_cyc_if.sv
/*
  carries one pin-cycle request from the sequencer to the strobe engine.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface nbr_cyc_if;
  logic req;
  nbr_pkg::nbr_cyc_type kind;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output kind, output wdata,
               input done, input rdata);
  modport eng (input req, input kind, input wdata,
               output done, output rdata);
endinterface : nbr_cyc_if
`default_nettype wire

// ===== core/nbr_sync.sv
/*
  three-stage synchroniser; the output changes only when stages two and
  three agree. assumes an asynchronous input and the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nbr_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  // shift chain; first stage only feeds the second
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level <= s3_ff;
      end
    end
  end
endmodule : nbr_sync
`default_nettype wire

// ===== core/nbr_strobe.sv
/*
  strobe engine: turns one cycle request into a command, address or read
  pin cycle with the low and high times of the package.
  assumes the sequencer holds kind and wdata while req is high.
*/
`timescale 1ns/1ps
`default_nettype none
module nbr_strobe (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request from the sequencer
  nbr_cyc_if.eng cyc,
  // device pins
  input wire logic [7:0] lanes_in,
  output logic [7:0] lanes_out,
  output logic lanes_oe_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10
  } nbr_stb_type;
  nbr_stb_type state_ff;
  logic [3:0] cnt_ff;
  logic is_read;
  assign is_read = (cyc.kind == nbr_pkg::CYC_READ);
  // cycle timer and phase
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cyc.req) begin
            state_ff <= ST_LOW;
            cnt_ff <= nbr_pkg::STROBE_LOW_CYC;
          end
        end
        ST_LOW: begin
          if (cnt_ff == 4'h1) begin
            state_ff <= ST_HIGH;
            cnt_ff <= nbr_pkg::STROBE_HIGH_CYC;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_HIGH: begin
          if (cnt_ff == 4'h1) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  // pin drive: latches and lanes held for the whole cycle, strobes low
  // only in the low phase; never both latches high together
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      lanes_out <= 8'h00;
      lanes_oe_n <= 1'b1;
    end else if (state_ff == ST_IDLE && cyc.req) begin
      cmd_latch <= (cyc.kind == nbr_pkg::CYC_CMD); // RULE10
      addr_latch <= (cyc.kind == nbr_pkg::CYC_ADDR); // RULE11
      write_strobe_n <= is_read;
      read_strobe_n <= !is_read; // RULE15
      lanes_out <= cyc.wdata;
      lanes_oe_n <= is_read;
    end else if (state_ff == ST_LOW && cnt_ff == 4'h1) begin
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
    end else if (state_ff == ST_HIGH && cnt_ff == 4'h1) begin
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      lanes_oe_n <= 1'b1;
    end
  end
  // read data sample: at the rising strobe, or in extended output mode at
  // the end of the cycle just before the next falling strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      cyc.rdata <= 8'h00;
    end else if (!nbr_pkg::EDO_MODE && state_ff == ST_LOW &&
                 cnt_ff == 4'h1 && !read_strobe_n) begin
      cyc.rdata <= lanes_in;
    end else if (nbr_pkg::EDO_MODE && state_ff == ST_HIGH &&
                 cnt_ff == 4'h1 && lanes_oe_n) begin
      cyc.rdata <= lanes_in; // RULE16
    end
  end
  assign cyc.done = (state_ff == ST_HIGH) && (cnt_ff == 4'h1);
endmodule : nbr_strobe
`default_nettype wire

// ===== dv/nbr_flash_model.sv
/*
  behavioural model of the flash device on the far side of the host pins:
  latches commands and addresses, goes busy after a load, streams bytes.
  assumes the strobes come from nbr_host and ready/busy is pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
module nbr_flash_model #(
  parameter int BUSY_NS = 1000,
  parameter logic [10:0] BAD_BLK = 11'h005,
  parameter logic [10:0] WEAK_BLK = 11'h006
) (
  // host pins
  input wire logic chip_select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic lanes_oe_n,
  input wire logic [7:0] lanes_out,
  // device answers
  output logic [7:0] lanes_in,
  output logic ready_busy_n,
  // observation
  output logic [18:0] loaded_row,
  output int viol
);
  logic [7:0] ab [5];
  logic [7:0] dout;
  logic [7:0] last;
  logic drive;
  logic busy;
  logic [12:0] ptr;
  int na;

  // page zero of block zero sits in the cache from power-up
  initial begin
    busy = 1'b0;
    ptr = 13'h0000;
    loaded_row = 19'h00000;
    na = 0;
    viol = 0;
    drive = 1'b0;
    last = 8'h00;
  end

  // pull-up wins unless busy; released lanes show the inverse of the last
  assign ready_busy_n = busy ? 1'b0 : 1'b1;
  assign lanes_in = !lanes_oe_n ? lanes_out : drive ? dout : ~last;

  // marker bytes and a pattern elsewhere
  function automatic logic [7:0] byte_at(logic [18:0] r, logic [12:0] c);
    if (c == 13'h0000 || c == 13'h1000) begin
      if (r[16:6] == BAD_BLK && r[5:0] == 6'h3f && c != 13'h0000) return 8'h07;
      if (r[16:6] == WEAK_BLK && r[5:0] == 6'h00 && c == 13'h0000) return 8'hfe;
      return 8'hff;
    end
    return c[7:0] ^ {r[5:0], 2'b01} ^ r[13:6];
  endfunction : byte_at

  // command decode; anything but 00h, 05h, 30h, 31h and E0h is counted as a fault
  task automatic take_cmd(logic [7:0] c);
    case (c)
      8'h00, 8'h05: na = 0;
      8'h30, 8'h31: begin
        if (na != 5 || ab[1][7:5] != 3'h0 || ab[4][7:3] != 5'h00) viol++;
        loaded_row = {ab[4][2:0], ab[3], ab[2]};
        ptr = {ab[1][4:0], ab[0]};
        busy = 1'b1;
        fork
          begin
            #(BUSY_NS);
            busy = 1'b0;
          end
        join_none
      end
      8'he0: begin
        if (na != 2 || busy) viol++;
        ptr = {ab[1][4:0], ab[0]};
      end
      default: viol++;
    endcase
  endtask : take_cmd

  // latch on the rising write strobe when selected and one latch is high
  always @(posedge write_strobe_n) begin
    if (busy) viol++;
    if (!chip_select_n && read_strobe_n && !(cmd_latch && addr_latch)) begin
      if (cmd_latch) take_cmd(lanes_out);
      else if (addr_latch) begin
        if (na < 5) ab[na] = lanes_out;
        na++;
      end
    end
  end

  // each falling read strobe presents the next byte up to the last column
  always @(negedge read_strobe_n) begin
    if (busy) viol++;
    if (!chip_select_n && !cmd_latch && !addr_latch) begin
      dout = byte_at(loaded_row, ptr);
      drive = 1'b1;
      if (ptr != 13'h10ff) ptr++;
    end
  end

  // short output hold after the strobe rises, then the lanes float
  always @(posedge read_strobe_n) begin
    last = dout;
    #5;
    drive = 1'b0;
  end
endmodule : nbr_flash_model
`default_nettype wire

// ===== dv/nbr_host_assertions.sv
/*
  pin-level checks of the host controller.
  assumes it is bound to nbr_host and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module nbr_host_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // user side
  input wire logic req_ready,
  // device pins
  input wire logic [7:0] lanes_out,
  input wire logic lanes_oe_n,
  input wire logic chip_select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic ready_busy_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // steps of one write-strobe cycle
  sequence wr_start_s;
    $fell(write_strobe_n);
  endsequence
  sequence wr_held_s;
    ($stable(lanes_out) && $stable(cmd_latch) && !write_strobe_n)[*3];
  endsequence

  latch_excl_a: assert property (
    !(cmd_latch && addr_latch)) else $error("both latches high");
  strobe_pair_a: assert property (
    write_strobe_n || read_strobe_n) else $error("both strobes low");
  wr_drive_a: assert property (
    !write_strobe_n |-> !lanes_oe_n && (cmd_latch ^ addr_latch))
    else $error("write strobe without one latch or lanes");
  rd_release_a: assert property (
    !read_strobe_n |-> lanes_oe_n && !cmd_latch && !addr_latch)
    else $error("host drives during read strobe");
  wr_cycle_a: assert property (
    wr_start_s |=> wr_held_s ##1 (write_strobe_n && $stable(lanes_out)))
    else $error("write strobe cycle wrong");
  busy_quiet_a: assert property (
    !ready_busy_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe while busy");
  busy_gate_a: assert property (
    !ready_busy_n [*6] |-> !req_ready) else $error("ready while busy");
  select_held_a: assert property (
    (cmd_latch || addr_latch || !read_strobe_n) |-> !chip_select_n)
    else $error("bus cycle without select");
  protect_low_a: assert property (
    !write_protect_n) else $error("write protect released");
endmodule : nbr_host_assertions

bind nbr_host nbr_host_assertions nbr_host_assertions_i (.clock, .rst,
  .req_ready, .lanes_out, .lanes_oe_n, .chip_select_n, .cmd_latch,
  .addr_latch, .write_strobe_n, .read_strobe_n, .write_protect_n,
  .ready_busy_n);
`default_nettype wire

// ===== dv/test_nbr_host.sv
/*
  self-checking bench of the host controller against the flash model.
  assumes the model streams its pattern and flags pin-order faults.
*/
`timescale 1ns/1ps
`default_nettype none
module test_nbr_host;
  localparam int LIMIT = 40000;
  logic clock, rst, req_valid, req_ready, rd_valid, done, bad_block;
  logic [1:0] req_op, density;
  logic [31:0] req_addr;
  logic [12:0] req_len;
  logic [7:0] rd_data, lanes_in, lanes_out;
  logic lanes_oe_n, chip_select_n, cmd_latch, addr_latch, write_strobe_n;
  logic read_strobe_n, write_protect_n, ready_busy_n;
  logic [18:0] loaded_row, cur_row;
  logic [31:0] a;
  int viol, failures, n_checks, cycles;

  nbr_host nbr_host_i (.clock, .rst, .req_valid, .req_ready, .req_op,
    .req_addr, .req_len, .density, .rd_valid, .rd_data, .done, .bad_block,
    .lanes_in, .lanes_out, .lanes_oe_n, .chip_select_n, .cmd_latch,
    .addr_latch, .write_strobe_n, .read_strobe_n, .write_protect_n,
    .ready_busy_n);
  nbr_flash_model nbr_flash_model_i (.chip_select_n, .cmd_latch,
    .addr_latch, .write_strobe_n, .read_strobe_n, .lanes_oe_n, .lanes_out,
    .lanes_in, .ready_busy_n, .loaded_row, .viol);

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // compare and count
  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // row address the device should see once unit bits are masked
  function automatic logic [18:0] mask_row(logic [31:0] x, logic [1:0] d);
    logic [18:0] r;
    r = x[31:13];
    if (d == 2'h0) r[18:17] = 2'b00;
    if (d == 2'h1) r[18] = 1'b0;
    return r;
  endfunction : mask_row

  // one user request: offer, wait for take, collect bytes up to done
  task automatic run(logic [1:0] op, logic [31:0] x, logic [12:0] n,
                     logic [1:0] d);
    int w, k, ex;
    logic [12:0] c;
    c = x[12:0];
    k = 0;
    w = 0;
    ex = (4352 - int'(c)) < int'(n) ? 4352 - int'(c) : int'(n);
    req_op <= op;
    req_addr <= x;
    req_len <= n;
    density <= d;
    req_valid <= 1'b1;
    do begin
      @(posedge clock);
      w++;
    end while (req_ready !== 1'b1 && w < 500);
    req_valid <= 1'b0;
    if (op == 2'h0 || op == 2'h3) cur_row = mask_row(x, d);
    while (w < 4000) begin
      @(posedge clock);
      w++;
      if (rd_valid === 1'b1 && op != 2'h2) begin
        check(rd_data, nbr_flash_model_i.byte_at(cur_row, c));
        c++;
        k++;
      end
      if (done === 1'b1) break;
    end
    if (w >= 4000) failures++;
    if (op == 2'h2) begin
      check(bad_block, x[29:19] == 11'h005);
      cur_row = mask_row(x, d);
      cur_row[5:0] = 6'h3f;
    end else check(k, ex);
    if (op == 2'h0 || op == 2'h3) check(loaded_row, cur_row);
  endtask : run

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop;
    end
  end

  // corner cases, random reads, screen and cache cases, then random traffic
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 32'h00000000;
    req_len = 13'h0000;
    density = 2'h2;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    cur_row = 19'h00000;
    void'($urandom(32'h816a8d8b));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    run(2'h1, 32'h00000005, 13'h0004, 2'h2);
    run(2'h0, {2'b11, 11'h123, 6'h3f, 13'h10fe}, 13'h0005, 2'h3);
    run(2'h1, 32'h000010ff, 13'h0003, 2'h2);
    run(2'h1, 32'h00001000, 13'h0001, 2'h2);
    for (int i = 0; i < 4; i++) begin
      a = $urandom;
      a[31:30] = 2'b11;
      a[12:0] = 13'($urandom_range(4351, 0));
      run(2'h0, a, 13'h0002, i[1:0]);
    end
    run(2'h2, {2'b00, 11'h005, 19'h00000}, 13'h0000, 2'h0);
    run(2'h2, {2'b00, 11'h006, 19'h00000}, 13'h0000, 2'h0);
    run(2'h3, {2'b01, 11'h07a, 6'h11, 13'h0000}, 13'h0006, 2'h2);
    for (int i = 0; i < 14; i++) begin
      a = $urandom;
      a[12:0] = 13'($urandom_range(4351, 0));
      if (i % 4 == 3) a[12:0] = 13'h0000;
      run(2'(i % 4), a, 13'($urandom_range(8, 0)), 2'($urandom_range(3, 0)));
    end
    check(viol, 0);
    report_and_stop;
  end
endmodule : test_nbr_host
`default_nettype wire
